// ---- page_op_pkg.sv ----
// Package: command codes, field layout, reset values and timing of the page/operation logic
package page_op_pkg;
    localparam int NUM_CH = 8;
    // Command codes
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_BCAST_MASK = 8'he4;
    // Page values
    localparam logic [7:0] PAGE_LAST = 8'h07;
    localparam logic [7:0] PAGE_BROADCAST = 8'hff;
    // Operation byte fields
    localparam int OP_RUN_LSB = 6;
    localparam int OP_MARGIN_LSB = 4;
    localparam int OP_FAULT_LSB = 2;
    localparam logic [1:0] RUN_OFF = 2'h0;
    localparam logic [1:0] RUN_SEQ_OFF = 2'h1;
    localparam logic [1:0] RUN_ON = 2'h2;
    localparam logic [1:0] MARGIN_NOM = 2'h0;
    localparam logic [1:0] MARGIN_LOW = 2'h1;
    localparam logic [1:0] MARGIN_HIGH = 2'h2;
    localparam logic [1:0] FAULT_IGNORE = 2'h1;
    localparam logic [1:0] FAULT_NORMAL = 2'h2;
    localparam logic [7:0] OP_KEEP_MASK = 8'hfc;
    // On/off configuration bits
    localparam int CFG_CONTROLLED_ON = 4;
    localparam int CFG_USE_BUS = 3;
    localparam int CFG_USE_PIN = 2;
    localparam int CFG_FAST_OFF = 0;
    localparam logic [7:0] CFG_KEEP_MASK = 8'h1d;
    localparam logic [7:0] CFG_READ_ONES = 8'h02;
    // Reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] OP_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h1e;
    localparam logic [7:0] MASK_RESET = 8'hff;
    // Read answers
    localparam logic [7:0] RDATA_UNDEF = 8'hff;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    // Timing
    localparam longint CLK_HZ = 64'd10_000_000;
    localparam longint INIT_TIME_MS = 64'd135;
    localparam longint INIT_CYCLES = INIT_TIME_MS * CLK_HZ / 64'd1000;
    localparam int INIT_CNT_W = 32;
    typedef enum logic [1:0] {PWR_INIT, PWR_WAIT_VIN, PWR_RUN} power_state_t;
endpackage

// ---- page_op_decode.sv ----
// Page selection, operation decode and power-up gating for eight channels
`timescale 1ns/1ps
module page_op_decode
    import page_op_pkg::*;
#(
    parameter longint INIT_CYCLES_P = INIT_CYCLES
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_link,
    input wire logic i_link_write,
    input wire logic i_link_read,
    input wire logic [7:0] i_link_command,
    input wire logic [7:0] i_link_wdata,
    output logic o_link_busy,
    output logic [7:0] o_link_rdata,
    output logic o_link_rvalid,
    input wire logic [NUM_CH-1:0] i_channel_control_pin,
    input wire logic i_input_voltage_sense,
    input wire logic i_cml_clear,
    output logic o_cml_fault,
    output logic o_init_done,
    output logic [NUM_CH-1:0] o_channel_enable,
    output logic [NUM_CH-1:0] o_channel_fast_off,
    output logic [NUM_CH-1:0] o_margin_low,
    output logic [NUM_CH-1:0] o_margin_high,
    output logic [NUM_CH-1:0] o_ignore_faults
);

    // ********************************************
    // Link domain: request capture and answer
    // ********************************************
    logic busy_reg;
    logic req_tgl_reg;
    logic rd_hold_reg;
    logic [7:0] cmd_hold_reg;
    logic [7:0] data_hold_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_s3_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic ack_tgl_reg;
    logic [7:0] rdata_xfer_reg;

    wire link_take = (i_link_write || i_link_read) && !busy_reg;
    wire link_ack = ack_s2_reg ^ ack_s3_reg;

    always_ff @(posedge i_clk_link or posedge i_reset)
    begin
        if (i_reset)
        begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            ack_s3_reg <= 1'b0;
        end
        else
        begin
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
        end
    end

    always_ff @(posedge i_clk_link or posedge i_reset)
    begin
        if (i_reset)
        begin
            busy_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            rd_hold_reg <= 1'b0;
            cmd_hold_reg <= 8'h00;
            data_hold_reg <= 8'h00;
        end
        else if (link_take)
        begin
            busy_reg <= 1'b1;
            req_tgl_reg <= !req_tgl_reg;
            rd_hold_reg <= i_link_read;
            cmd_hold_reg <= i_link_command;
            data_hold_reg <= i_link_wdata;
        end
        else if (link_ack)
        begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_link or posedge i_reset)
    begin
        if (i_reset)
        begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= link_ack && rd_hold_reg;
            if (link_ack && rd_hold_reg)
            begin
                rdata_reg <= rdata_xfer_reg;
            end
        end
    end

    assign o_link_busy = busy_reg;
    assign o_link_rdata = rdata_reg;
    assign o_link_rvalid = rvalid_reg;

    // ********************************************
    // System domain: synchronisers
    // ********************************************
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_s3_reg;
    logic vin_s1_reg;
    logic vin_s2_reg;
    logic [NUM_CH-1:0] pin_s1_reg;
    logic [NUM_CH-1:0] pin_s2_reg;

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
            vin_s1_reg <= 1'b0;
            vin_s2_reg <= 1'b0;
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            vin_s1_reg <= i_input_voltage_sense;
            vin_s2_reg <= vin_s1_reg;
            pin_s1_reg <= i_channel_control_pin;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ********************************************
    // Command decode
    // ********************************************
    function automatic logic [NUM_CH-1:0] page_targets(input logic [7:0] page,
                                                        input logic [7:0] mask);
        logic [NUM_CH-1:0] sel;
        sel = '0;
        if (page == PAGE_BROADCAST)
            sel = mask;
        else if (page <= PAGE_LAST)
            sel[page[2:0]] = 1'b1;
        return sel;
    endfunction

    logic [7:0] page_reg;
    logic [7:0] mask_reg;
    logic [7:0] op_reg [NUM_CH];
    logic [7:0] cfg_reg [NUM_CH];
    logic cml_reg;

    wire req_evt = req_s2_reg ^ req_s3_reg;
    wire evt_wr = req_evt && !rd_hold_reg;
    wire evt_rd = req_evt && rd_hold_reg;
    wire page_ok = (data_hold_reg <= PAGE_LAST) || (data_hold_reg == PAGE_BROADCAST);
    wire page_bcast = page_reg == PAGE_BROADCAST;
    wire wr_page = evt_wr && cmd_hold_reg == CMD_PAGE && page_ok;
    wire wr_mask = evt_wr && cmd_hold_reg == CMD_BCAST_MASK;
    wire wr_op = evt_wr && cmd_hold_reg == CMD_OPERATION;
    wire wr_cfg = evt_wr && cmd_hold_reg == CMD_ON_OFF_CONFIG;
    wire cmd_paged = cmd_hold_reg == CMD_OPERATION || cmd_hold_reg == CMD_ON_OFF_CONFIG;
    wire rd_undef = evt_rd && cmd_paged && page_bcast;
    wire [NUM_CH-1:0] wr_sel = page_targets(page_reg, mask_reg);
    wire [2:0] page_idx = page_reg[2:0];
    wire [7:0] op_cur = op_reg[page_idx] & OP_KEEP_MASK;
    wire [7:0] cfg_cur = (cfg_reg[page_idx] & CFG_KEEP_MASK) | CFG_READ_ONES;

    logic [7:0] rdata_next;
    always_comb
    begin
        case (cmd_hold_reg)
            CMD_PAGE: rdata_next = page_reg;
            CMD_BCAST_MASK: rdata_next = mask_reg;
            CMD_OPERATION: rdata_next = page_bcast ? RDATA_UNDEF : op_cur;
            CMD_ON_OFF_CONFIG: rdata_next = page_bcast ? RDATA_UNDEF : cfg_cur;
            default: rdata_next = RDATA_NONE;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            ack_tgl_reg <= 1'b0;
            rdata_xfer_reg <= 8'h00;
        end
        else if (req_evt)
        begin
            ack_tgl_reg <= !ack_tgl_reg;
            rdata_xfer_reg <= rdata_next;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            page_reg <= PAGE_RESET;
            mask_reg <= MASK_RESET;
            cml_reg <= 1'b0;
        end
        else
        begin
            if (wr_page)
                page_reg <= data_hold_reg;
            if (wr_mask)
                mask_reg <= data_hold_reg;
            cml_reg <= rd_undef || (cml_reg && !i_cml_clear);
        end
    end

    // Broadcast and single-page writes share one path
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                op_reg[ch] <= OP_RESET;
                cfg_reg[ch] <= CFG_RESET;
            end
        end
        else
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                if (wr_op && wr_sel[ch])
                    op_reg[ch] <= data_hold_reg & OP_KEEP_MASK;
                if (wr_cfg && wr_sel[ch])
                    cfg_reg[ch] <= data_hold_reg & CFG_KEEP_MASK;
            end
        end
    end

    // ********************************************
    // Power-up gating
    // ********************************************
    power_state_t pwr_state;
    power_state_t pwr_next;
    logic [INIT_CNT_W-1:0] init_cnt_reg;
    localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES_P - 64'd1);
    wire init_end = init_cnt_reg == INIT_LAST;

    always_comb
    begin
        case (pwr_state)
            PWR_INIT: pwr_next = init_end ? PWR_WAIT_VIN : PWR_INIT;
            PWR_WAIT_VIN: pwr_next = vin_s2_reg ? PWR_RUN : PWR_WAIT_VIN;
            PWR_RUN: pwr_next = vin_s2_reg ? PWR_RUN : PWR_WAIT_VIN;
            default: pwr_next = PWR_INIT;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            pwr_state <= PWR_INIT;
            init_cnt_reg <= '0;
        end
        else
        begin
            pwr_state <= pwr_next;
            if (pwr_state == PWR_INIT && !init_end)
                init_cnt_reg <= init_cnt_reg + 1'b1;
        end
    end

    wire run_ok = pwr_state == PWR_RUN;

    // ********************************************
    // Per-channel on/off and margin decode
    // ********************************************
    logic [NUM_CH-1:0] ch_on;
    logic [NUM_CH-1:0] ch_fast;
    logic [NUM_CH-1:0] ch_low;
    logic [NUM_CH-1:0] ch_high;
    logic [NUM_CH-1:0] ch_ign;

    for (genvar g = 0; g < NUM_CH; g++)
    begin : gen_ch
        wire [1:0] run = op_reg[g][OP_RUN_LSB +: 2];
        wire [1:0] mrg = op_reg[g][OP_MARGIN_LSB +: 2];
        wire [1:0] flt = op_reg[g][OP_FAULT_LSB +: 2];
        wire use_bus = cfg_reg[g][CFG_USE_BUS];
        wire use_pin = cfg_reg[g][CFG_USE_PIN];
        wire gated = cfg_reg[g][CFG_CONTROLLED_ON];
        wire bus_ok = !use_bus || run == RUN_ON;
        wire pin_ok = !use_pin || pin_s2_reg[g];
        wire mrg_ok = flt == FAULT_IGNORE || flt == FAULT_NORMAL;
        assign ch_on[g] = !gated || ((use_bus || use_pin) && bus_ok && pin_ok);
        assign ch_fast[g] = (use_bus && run == RUN_OFF)
                          || (use_pin && !pin_s2_reg[g] && cfg_reg[g][CFG_FAST_OFF]);
        assign ch_low[g] = mrg == MARGIN_LOW && mrg_ok;
        assign ch_high[g] = mrg == MARGIN_HIGH && mrg_ok;
        assign ch_ign[g] = (ch_low[g] || ch_high[g]) && flt == FAULT_IGNORE;
    end

    logic [NUM_CH-1:0] en_reg;
    logic [NUM_CH-1:0] fast_reg;
    logic [NUM_CH-1:0] low_reg;
    logic [NUM_CH-1:0] high_reg;
    logic [NUM_CH-1:0] ign_reg;
    logic init_done_reg;

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            en_reg <= '0;
            fast_reg <= '0;
            low_reg <= '0;
            high_reg <= '0;
            ign_reg <= '0;
            init_done_reg <= 1'b0;
        end
        else
        begin
            en_reg <= run_ok ? ch_on : '0;
            fast_reg <= ch_fast;
            low_reg <= ch_low;
            high_reg <= ch_high;
            ign_reg <= ch_ign;
            init_done_reg <= pwr_state != PWR_INIT;
        end
    end

    assign o_channel_enable = en_reg;
    assign o_channel_fast_off = fast_reg;
    assign o_margin_low = low_reg;
    assign o_margin_high = high_reg;
    assign o_ignore_faults = ign_reg;
    assign o_init_done = init_done_reg;
    assign o_cml_fault = cml_reg;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    page_hold_a: assert property (!wr_page |=> $stable(page_reg))
        else $error("page changed without a page write");
    page_range_a: assert property (page_reg <= PAGE_LAST || page_reg == PAGE_BROADCAST)
        else $error("page holds a reserved value");
    bcast_write_a: assert property ((wr_op && page_bcast && mask_reg[0])
        |=> op_reg[0] == ($past(data_hold_reg) & OP_KEEP_MASK))
        else $error("broadcast write missed masked channel");
    other_cmd_a: assert property ((evt_wr && !cmd_paged) |=> $stable(op_reg[7]))
        else $error("operation changed by another command");
    cml_fault_a: assert property (rd_undef |=> cml_reg [*2])
        else $error("undefined read raised no fault");
    rsvd_bits_a: assert property ((evt_rd && cmd_hold_reg == CMD_OPERATION && !page_bcast)
        |=> rdata_xfer_reg[1:0] == 2'b00)
        else $error("reserved operation bits read nonzero");
    run_gate_a: assert property (o_channel_enable[0] |-> $past(pwr_state) == PWR_RUN)
        else $error("channel enabled before input voltage ready");
    init_wait_a: assert property ((pwr_state == PWR_INIT && !init_end) |=> pwr_state == PWR_INIT)
        else $error("initialisation ended early");
    bus_off_a: assert property ((run_ok && cfg_reg[0][CFG_USE_BUS] && cfg_reg[0][CFG_CONTROLLED_ON]
        && op_reg[0][OP_RUN_LSB +: 2] == RUN_OFF) |=> !o_channel_enable[0] && o_channel_fast_off[0])
        else $error("bus off command did not turn channel off");
    margin_low_a: assert property (o_margin_low[0] |-> $past(op_reg[0][OP_MARGIN_LSB +: 2]) == MARGIN_LOW)
        else $error("margin low without low selection");

    bcast_c: cover property (wr_op && page_bcast);
    undef_read_c: cover property (rd_undef);
    run_c: cover property (pwr_state == PWR_WAIT_VIN ##1 pwr_state == PWR_RUN);
    enable_c: cover property ($rose(o_channel_enable[0]));

endmodule

// ---- pmbus_host_model.sv ----
// Host controller model issuing single-byte command transactions on the link port
`timescale 1ns/1ps
module pmbus_host_model
(
    input wire logic i_clk_link,
    input wire logic i_link_busy,
    input wire logic [7:0] i_link_rdata,
    input wire logic i_link_rvalid,
    output logic o_link_write,
    output logic o_link_read,
    output logic [7:0] o_link_command,
    output logic [7:0] o_link_wdata
);
    initial
    begin
        o_link_write = 1'b0;
        o_link_read = 1'b0;
        o_link_command = 8'h00;
        o_link_wdata = 8'h00;
    end

    // ****************************************
    // One transfer: request held for the take edge, then wait for busy to drop
    // ****************************************
    task automatic transact(input logic rd, input logic [7:0] cmd, input logic [7:0] data,
                            output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge i_clk_link);
        o_link_write <= !rd;
        o_link_read <= rd;
        o_link_command <= cmd;
        o_link_wdata <= data;
        @(posedge i_clk_link);
        // Released command and data lines show the inverse so stale values are never trusted; write and read drop to 0
        o_link_write <= 1'b0;
        o_link_read <= 1'b0;
        o_link_command <= ~cmd;
        o_link_wdata <= ~data;
        do
        begin
            @(posedge i_clk_link);
            n++;
        end
        while (i_link_busy !== 1'b0 && n < 300);
        rdata = i_link_rvalid ? i_link_rdata : ~i_link_rdata;
    endtask
endmodule

// ---- page_op_decode_test.sv ----
// Self-checking testbench of the page selection and operation decode block
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module page_op_decode_test;
    import page_op_pkg::*;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic reset = 1'b1;
    logic sense = 1'b0;
    logic cml_clear = 1'b0;
    logic [NUM_CH-1:0] pins = 8'h00;
    logic link_write, link_read, busy, rvalid, cml_fault, init_done;
    logic [7:0] command, wdata, rdata, d;
    logic [NUM_CH-1:0] en, fo, ml, mh, ig;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] op_tab [0:6] = '{8'h80, 8'h94, 8'h98, 8'ha4, 8'ha8, 8'h40, 8'h00};
    // Expected {enable, fast_off, margin_low, margin_high, ignore} of channel 0
    logic [4:0] exp_tab [0:6] = '{5'h10, 5'h15, 5'h14, 5'h13, 5'h12, 5'h00, 5'h08};
    // Channels 2, 5 and 7 keep reset config and reset run-off code, so fast-off stands
    localparam logic [NUM_CH-1:0] FO_IDLE = 8'ha4;
    // Scaled extra wait before readback is trusted
    localparam int READBACK_WAIT = 16;
    logic [39:0] exp_v;

    always #50 clk_sys = ~clk_sys;
    always #3 clk_link = ~clk_link;

    page_op_decode #(.INIT_CYCLES_P(64'd20)) dut
    (
        .i_clk_sys(clk_sys), .i_reset(reset), .i_clk_link(clk_link),
        .i_link_write(link_write), .i_link_read(link_read), .i_link_command(command),
        .i_link_wdata(wdata), .o_link_busy(busy), .o_link_rdata(rdata),
        .o_link_rvalid(rvalid), .i_channel_control_pin(pins),
        .i_input_voltage_sense(sense), .i_cml_clear(cml_clear), .o_cml_fault(cml_fault),
        .o_init_done(init_done), .o_channel_enable(en), .o_channel_fast_off(fo),
        .o_margin_low(ml), .o_margin_high(mh), .o_ignore_faults(ig)
    );

    pmbus_host_model host
    (
        .i_clk_link(clk_link), .i_link_busy(busy), .i_link_rdata(rdata),
        .i_link_rvalid(rvalid), .o_link_write(link_write), .o_link_read(link_read),
        .o_link_command(command), .o_link_wdata(wdata)
    );

    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        logic [7:0] unused;
        host.transact(1'b0, cmd, data, unused);
    endtask

    task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
        host.transact(1'b1, cmd, 8'h00, data);
    endtask

    task automatic sys_wait(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        sys_wait(10);
        reset <= 1'b0;
        sys_wait(15);
        `CHECK({init_done, en}, 9'h000)
        sys_wait(10);
        `CHECK(init_done, 1'b1)
        sys_wait(READBACK_WAIT);
        rd(CMD_PAGE, d); `CHECK(d, PAGE_RESET)
        rd(CMD_OPERATION, d); `CHECK(d, OP_RESET)
        rd(CMD_ON_OFF_CONFIG, d); `CHECK(d, CFG_RESET)
        rd(CMD_BCAST_MASK, d); `CHECK(d, MASK_RESET)
        wr(CMD_BCAST_MASK, 8'h5a);
        rd(CMD_BCAST_MASK, d); `CHECK(d, 8'h5a)
        wr(CMD_PAGE, PAGE_BROADCAST);
        rd(CMD_PAGE, d); `CHECK(d, PAGE_BROADCAST)
        wr(CMD_PAGE, 8'h09);
        rd(CMD_PAGE, d); `CHECK(d, PAGE_BROADCAST)
        rd(CMD_OPERATION, d); `CHECK(d, RDATA_UNDEF)
        sys_wait(4);
        `CHECK(cml_fault, 1'b1)
        cml_clear <= 1'b1;
        sys_wait(2);
        cml_clear <= 1'b0;
        sys_wait(2);
        `CHECK(cml_fault, 1'b0)
        // Masked channels become unconditionally on, but only after input is good
        wr(CMD_ON_OFF_CONFIG, 8'h00);
        sys_wait(6);
        `CHECK(en, 8'h00)
        sense <= 1'b1;
        sys_wait(6);
        `CHECK(en, 8'h5a)
        pins <= 8'h01;
        wr(CMD_PAGE, 8'h00);
        for (int i = 0; i < 7; i++)
        begin
            wr(CMD_OPERATION, op_tab[i]);
            sys_wait(3);
            exp_v = {8'h5a | {7'h0, exp_tab[i][4]}, FO_IDLE | {7'h0, exp_tab[i][3]},
                     {7'h0, exp_tab[i][2]}, {7'h0, exp_tab[i][1]}, {7'h0, exp_tab[i][0]}};
            `CHECK({en, fo, ml, mh, ig}, exp_v)
        end
        wr(CMD_OPERATION, 8'h83);
        rd(CMD_OPERATION, d); `CHECK(d, 8'h80)
        // Bus control off: run field ignored, margin still applied
        wr(CMD_ON_OFF_CONFIG, 8'h14);
        wr(CMD_OPERATION, 8'h14);
        sys_wait(3);
        `CHECK({en, fo, ml, ig}, {8'h5b, FO_IDLE, 8'h01, 8'h01})
        rd(CMD_ON_OFF_CONFIG, d); `CHECK(d, 8'h16)
        pins <= 8'h00;
        sys_wait(6);
        `CHECK({en, fo}, {8'h5a, FO_IDLE})
        sense <= 1'b0;
        sys_wait(6);
        `CHECK(en, 8'h00)
        tally_and_finish();
    end
endmodule
